// ### core/tcw_pkg.sv
// Package for the calibration walker: addresses, tags, offsets, registers
package tcw_pkg;
  localparam logic [15:0] SEG_BASE      = 16'h10C0;
  localparam logic [15:0] FIRST_TAG     = 16'h10C2;
  localparam logic [15:0] SEG_END       = 16'h10FF;
  localparam int          SEG_WORDS     = 31;
  localparam logic [7:0]  TAG_EMPTY     = 8'hFE;
  localparam logic [7:0]  OSC_CAL_TAG   = 8'h01;
  localparam logic [7:0]  CONV_CAL_TAG  = 8'h08;
  localparam logic [7:0]  OSC_STEP_MIN  = 8'h00;
  localparam int          FRAC_BITS     = 15;
  // Converter record word offsets (bytes past the record data start)
  localparam logic [3:0]  OFF_GAIN      = 4'h0;
  localparam logic [3:0]  OFF_OFFSET    = 4'h2;
  localparam logic [3:0]  OFF_LOW_REF   = 4'h4;
  localparam logic [3:0]  OFF_LOW_T30   = 4'h6;
  localparam logic [3:0]  OFF_LOW_T85   = 4'h8;
  localparam logic [3:0]  OFF_HIGH_REF  = 4'hA;
  localparam logic [3:0]  OFF_HIGH_T30  = 4'hC;
  localparam logic [3:0]  OFF_HIGH_T85  = 4'hE;
  localparam int          CONV_WORDS    = 8;
  // Wishbone register byte addresses
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_IRQ       = 8'h08;
  localparam logic [7:0]  REG_MASK      = 8'h0C;
  localparam logic [7:0]  REG_RAW       = 8'h10;
  localparam logic [7:0]  REG_RESULT    = 8'h14;
  localparam logic [7:0]  REG_CAL_BASE  = 8'h20;
  localparam logic [7:0]  REG_OSC       = 8'h40;
  localparam logic [2:0]  MASK_RESET    = 3'h0;
  localparam logic [1:0]  FREQ_RESET    = 2'h0;
  // Interrupt bits
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_BAD_SUM   = 1;
  localparam int          IRQ_CORR      = 2;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_SUM_RD = 4'b0001,
    ST_SUM_CK = 4'b0010,
    ST_TAG_RD = 4'b0011,
    ST_DECODE = 4'b0100,
    ST_DAT_RD = 4'b0101,
    ST_OSC_CLR= 4'b0110,
    ST_OSC_RNG= 4'b0111,
    ST_OSC_STP= 4'b1000,
    ST_NEXT   = 4'b1001,
    ST_DONE   = 4'b1010
  } tcw_state_t;
endpackage : tcw_pkg

// ### core/tcw_walker.sv
// Calibration record walker with Wishbone registers and correction unit
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Base word is a checksum over every byte from first tag up.
// - XOR of 31 data words plus checksum must be zero, else data unused.
// - Record search starts at first tag address; byte there is a tag code.
// - Byte after the tag is an unsigned record length.
// - Next tag sits at tag address plus two plus length.
// - Chain followed over whole segment, for records at even addresses only; the walker also chains to an odd next tag address without checking.
// - Tag 0xFE unused, 0x01 oscillator data, 0x08 converter data.
// - Oscillator pairs: 1 MHz range at offset 7, 16 MHz step at 0.
// - Range byte goes to range select, step byte to step/modulation.
// - Clear step/modulation first, then write range, then step.
// - Converter record: eight words; gain at 0, offset at 2, low ref at 4.
// - Temperature results at 6, 8, 0xC, 0xE; high ref factor at 0xA.
// - Reference factor is measured over nominal voltage times 2^15.
// - Correction: raw result times reference factor, divided by 2^15.
// - Oscillator data is read relative to its tag location.
// - With gain and offset, apply gain first then add signed offset.
module tcw_walker (
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  // Information memory word read port, one cycle latency
  output logic             info_rd,
  output logic      [15:0] info_addr,
  input  wire logic [15:0] info_rdata,
  // Clock control register write ports
  output logic             range_select_we,
  output logic      [7:0]  range_select_reg,
  output logic             osc_step_mod_we,
  output logic      [7:0]  osc_step_mod_reg
);
  logic                 rst_s1;
  logic                 rst_n;
  tcw_pkg::tcw_state_t  state;
  logic [15:0]          tag_addr;
  logic [15:0]          rd_addr;
  logic [15:0]          sum;
  logic [7:0]           len;
  logic [7:0]           tag;
  logic [3:0]           idx;
  logic                 rd_pend;
  logic                 sum_bad;
  logic                 osc_seen;
  logic                 conv_seen;
  logic [15:0]          conv_cal [tcw_pkg::CONV_WORDS];
  logic [7:0]           osc_rng;
  logic [7:0]           osc_stp;
  logic [1:0]           freq_sel;
  logic [2:0]           irq_mask;
  logic [2:0]           irq_stat;
  logic [2:0]           irq_set;
  logic [2:0]           corr_mode;
  logic [11:0]          raw;
  logic [15:0]          result;
  logic                 start;
  logic                 corr_go;

  // Reset release through two flops
  // Assert at once, release only after two clean edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Bus decode
  // Ack blocks a second take of a request still held
  wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
  wire        wb_rd    = wb_req & ~wb_we_i;
  wire        wr_ctrl  = wb_wr && wb_adr_i == tcw_pkg::REG_CTRL;
  wire        wr_mask  = wb_wr && wb_adr_i == tcw_pkg::REG_MASK;
  wire        wr_raw   = wb_wr && wb_adr_i == tcw_pkg::REG_RAW;
  wire        rd_irq   = wb_rd && wb_adr_i == tcw_pkg::REG_IRQ;
  wire        busy     = state != tcw_pkg::ST_IDLE;
  wire        cal_hit  = wb_adr_i[7:5] == 3'b001 && wb_adr_i[1:0] == 2'b00;
  wire [2:0]  cal_idx  = wb_adr_i[4:2];

  // Record data index within word-aligned reads
  // A wrap past the top address is caught when chaining
  wire [15:0] next_tag = tag_addr + 16'd2 + {8'h00, len};
  wire [7:0]  hi_byte  = info_rdata[15:8];
  wire [7:0]  lo_byte  = info_rdata[7:0];
  // Pair offset: 1 MHz at 6/7 down to 16 MHz at 0/1
  wire [3:0]  osc_off  = {1'b0, ~freq_sel, 1'b0};

  // Gain then offset; selected factor then 2^15 scale
  wire [15:0] factor   = corr_mode[1] ? conv_cal[tcw_pkg::OFF_GAIN[3:1]] :
                         corr_mode[0] ? conv_cal[tcw_pkg::OFF_HIGH_REF[3:1]] :
                                        conv_cal[tcw_pkg::OFF_LOW_REF[3:1]];
  // Raw is 12 bits and factor 16, so the scaled part fits 13 bits
  wire [27:0] product  = {16'h0000, raw} * {12'h000, factor};
  wire [15:0] scaled   = product[tcw_pkg::FRAC_BITS +: 13] > 13'h0 ?
                         {3'b000, product[tcw_pkg::FRAC_BITS +: 13]} : 16'h0;
  wire [15:0] with_off = scaled + conv_cal[tcw_pkg::OFF_OFFSET[3:1]];
  // Without a converter record the raw value passes unchanged
  wire [15:0] corr_val = !conv_seen ? {4'h0, raw} :
                         corr_mode[2] ? with_off : scaled;

  assign irq = |(irq_stat & irq_mask);

  // Bad sum raised as the walk ends, once sum_bad already stands
  wire        walk_end = state == tcw_pkg::ST_DONE;
  wire        bad_end  = walk_end && sum_bad;
  assign irq_set = {corr_go, bad_end, walk_end};

  // Wishbone slave: one-cycle ack, unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      irq_mask  <= tcw_pkg::MASK_RESET;
      freq_sel  <= tcw_pkg::FREQ_RESET;
      corr_mode <= 3'h0;
      raw       <= 12'h000;
      start     <= 1'b0;
      corr_go   <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      // Start while busy is dropped, not queued
      start    <= wr_ctrl & wb_dat_i[0] & ~busy;
      corr_go  <= wr_raw;
      if (wr_ctrl) begin
        freq_sel  <= wb_dat_i[2:1];
        corr_mode <= wb_dat_i[5:3];
      end
      if (wr_mask)
        irq_mask <= wb_dat_i[2:0];
      if (wr_raw)
        raw <= wb_dat_i[11:0];
      // Unmapped reads return zero; unmapped writes vanish
      if (wb_rd) begin
        case (wb_adr_i)
          tcw_pkg::REG_CTRL:   wb_dat_o <= {26'h0, corr_mode[2:0],
                                            freq_sel, 1'b0};
          tcw_pkg::REG_STATUS: wb_dat_o <= {27'h0, conv_seen, osc_seen,
                                            sum_bad, ~busy, busy};
          tcw_pkg::REG_IRQ:    wb_dat_o <= {29'h0, irq_stat};
          tcw_pkg::REG_MASK:   wb_dat_o <= {29'h0, irq_mask};
          tcw_pkg::REG_RAW:    wb_dat_o <= {20'h0, raw};
          tcw_pkg::REG_RESULT: wb_dat_o <= {16'h0, result};
          tcw_pkg::REG_OSC:    wb_dat_o <= {16'h0, osc_rng, osc_stp};
          default:             wb_dat_o <= cal_hit ?
                                 {16'h0, conv_cal[cal_idx]} : 32'h0000_0000;
        endcase
      end
    end
  end

  // Sticky status, read clears, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      irq_stat <= 3'h0;
    else
      irq_stat <= (rd_irq ? 3'h0 : irq_stat) | irq_set;
  end

  // Corrected result register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      result <= 16'h0000;
    else if (corr_go)
      result <= corr_val;
  end

  // Walker
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state            <= tcw_pkg::ST_IDLE;
      tag_addr         <= tcw_pkg::FIRST_TAG;
      rd_addr          <= tcw_pkg::SEG_BASE;
      sum              <= 16'h0000;
      len              <= 8'h00;
      tag              <= 8'h00;
      idx              <= 4'h0;
      rd_pend          <= 1'b0;
      sum_bad          <= 1'b0;
      osc_seen         <= 1'b0;
      conv_seen        <= 1'b0;
      osc_rng          <= 8'h00;
      osc_stp          <= 8'h00;
      info_rd          <= 1'b0;
      info_addr        <= 16'h0000;
      range_select_we  <= 1'b0;
      range_select_reg <= 8'h00;
      osc_step_mod_we  <= 1'b0;
      osc_step_mod_reg <= 8'h00;
      for (int i = 0; i < tcw_pkg::CONV_WORDS; i++)
        conv_cal[i] <= 16'h0000;
    end else begin
      info_rd         <= 1'b0;
      range_select_we <= 1'b0;
      osc_step_mod_we <= 1'b0;
      case (state)
        tcw_pkg::ST_IDLE: begin
          if (start) begin
            rd_addr   <= tcw_pkg::SEG_BASE;
            sum       <= 16'h0000;
            sum_bad   <= 1'b0;
            osc_seen  <= 1'b0;
            conv_seen <= 1'b0;
            rd_pend   <= 1'b0;
            state     <= tcw_pkg::ST_SUM_RD;
          end
        end
        tcw_pkg::ST_SUM_RD: begin
          // One read in flight; data stands the cycle after it
          if (!rd_pend) begin
            info_rd   <= 1'b1;
            info_addr <= rd_addr;
            rd_pend   <= 1'b1;
          end else if (!info_rd) begin
            rd_pend <= 1'b0;
            if (rd_addr == tcw_pkg::SEG_BASE)
              sum <= sum;
            else
              sum <= sum ^ info_rdata;
            rd_addr <= rd_addr + 16'd2;
            if (rd_addr == tcw_pkg::SEG_END - 16'd1)
              state <= tcw_pkg::ST_SUM_CK;
          end
        end
        tcw_pkg::ST_SUM_CK: begin
          // Base word held aside: read it last
          if (!rd_pend) begin
            info_rd   <= 1'b1;
            info_addr <= tcw_pkg::SEG_BASE;
            rd_pend   <= 1'b1;
          end else if (!info_rd) begin
            rd_pend <= 1'b0;
            if ((sum + info_rdata) != 16'h0000) begin
              sum_bad <= 1'b1;
              state   <= tcw_pkg::ST_DONE;
            end else begin
              tag_addr <= tcw_pkg::FIRST_TAG;
              state    <= tcw_pkg::ST_TAG_RD;
            end
          end
        end
        tcw_pkg::ST_TAG_RD: begin
          if (!rd_pend) begin
            info_rd   <= 1'b1;
            info_addr <= tag_addr;
            rd_pend   <= 1'b1;
          end else if (!info_rd) begin
            rd_pend <= 1'b0;
            tag   <= lo_byte;
            len   <= hi_byte;
            idx   <= 4'h0;
            state <= tcw_pkg::ST_DECODE;
          end
        end
        tcw_pkg::ST_DECODE: begin
          case (tag)
            tcw_pkg::OSC_CAL_TAG,
            tcw_pkg::CONV_CAL_TAG: state <= tcw_pkg::ST_DAT_RD;
            default:               state <= tcw_pkg::ST_NEXT;
          endcase
        end
        tcw_pkg::ST_DAT_RD: begin
          if (!rd_pend) begin
            info_rd   <= 1'b1;
            info_addr <= tag_addr + 16'd2 +
                         {12'h000, tag == tcw_pkg::OSC_CAL_TAG ? osc_off : idx};
            rd_pend   <= 1'b1;
          end else if (!info_rd) begin
            rd_pend <= 1'b0;
            if (tag == tcw_pkg::OSC_CAL_TAG) begin
              // range upper, step lower
              // Only the chosen pair is read; others stay untouched
              osc_rng  <= hi_byte;
              osc_stp  <= lo_byte;
              osc_seen <= 1'b1;
              state    <= tcw_pkg::ST_OSC_CLR;
            end else begin
              // store eight words
              // Words land by index, so the slot follows the offset
              conv_cal[idx[3:1]] <= info_rdata;
              idx <= idx + 4'd2;
              if (idx == tcw_pkg::OFF_HIGH_T85) begin
                conv_seen <= 1'b1;
                state     <= tcw_pkg::ST_NEXT;
              end
            end
          end
        end
        tcw_pkg::ST_OSC_CLR: begin
          // lowest step first
          // Keeps the oscillator low while the range changes
          osc_step_mod_we  <= 1'b1;
          osc_step_mod_reg <= tcw_pkg::OSC_STEP_MIN;
          state            <= tcw_pkg::ST_OSC_RNG;
        end
        tcw_pkg::ST_OSC_RNG: begin
          range_select_we  <= 1'b1;
          range_select_reg <= osc_rng;
          state            <= tcw_pkg::ST_OSC_STP;
        end
        tcw_pkg::ST_OSC_STP: begin
          osc_step_mod_we  <= 1'b1;
          osc_step_mod_reg <= osc_stp;
          state            <= tcw_pkg::ST_NEXT;
        end
        tcw_pkg::ST_NEXT: begin
          // chain to segment end
          // A length running past the segment end stops the walk
          tag_addr <= next_tag;
          if (next_tag >= tcw_pkg::SEG_END || next_tag < tag_addr)
            state <= tcw_pkg::ST_DONE;
          else
            state <= tcw_pkg::ST_TAG_RD;
        end
        tcw_pkg::ST_DONE: state <= tcw_pkg::ST_IDLE;
        default:          state <= tcw_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : tcw_walker
`default_nettype wire

// ### dv/tcw_walker_props.sv
// Port assertions for the calibration walker
`timescale 1ns/1ps
`default_nettype none
module tcw_walker_props (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq,
  input wire logic        info_rd,
  input wire logic [15:0] info_addr,
  input wire logic [15:0] info_rdata,
  input wire logic        range_select_we,
  input wire logic [7:0]  range_select_reg,
  input wire logic        osc_step_mod_we,
  input wire logic [7:0]  osc_step_mod_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence load_s;
    range_select_we ##1 osc_step_mod_we;
  endsequence
  sequence gap_s;
    !info_rd ##1 !info_rd;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not answered next cycle");
  ack_in_cycle_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without a request");
  read_gap_a: assert property (info_rd |=> gap_s)
    else $error("flash reads closer than three cycles");
  read_range_a: assert property (info_rd |-> !info_addr[0] &&
    info_addr >= tcw_pkg::SEG_BASE && info_addr <= 16'h10FE)
    else $error("flash read outside the segment");
  clear_first_a: assert property (range_select_we |->
    $past(osc_step_mod_we) && $past(osc_step_mod_reg) == 8'h00)
    else $error("range written without prior step clear");
  load_order_a: assert property (osc_step_mod_we &&
    osc_step_mod_reg == 8'h00 && !$past(range_select_we) |=> load_s)
    else $error("clear not followed by range then step");
  irq_clear_a: assert property ($fell(irq) |-> wb_ack_o || $past(wb_ack_o))
    else $error("interrupt dropped without a bus access");
endmodule : tcw_walker_props
bind tcw_walker tcw_walker_props u_props (.clk, .arst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .irq, .info_rd, .info_addr, .info_rdata, .range_select_we,
  .range_select_reg, .osc_step_mod_we, .osc_step_mod_reg);
`default_nettype wire

// ### dv/tcw_flash_model.sv
// Information segment model with a one-word read port
`timescale 1ns/1ps
`default_nettype none
module tcw_flash_model (
  input  wire logic        clk,
  input  wire logic        info_rd,
  input  wire logic [15:0] info_addr,
  output logic      [15:0] info_rdata
);
  logic [15:0] mem [0:31];
  logic [15:0] held  = 16'h5A5A;
  logic        valid = 1'b0;
  // word zero holds the checksum
  // Word stands the cycle after the request; else a moving pattern
  assign info_rdata = valid ? held : ~held;
  always @(posedge clk) begin
    valid <= info_rd;
    held  <= info_rd ? mem[info_addr[5:1]] : ~held;
  end
endmodule : tcw_flash_model
`default_nettype wire

// ### dv/tcw_walker_bench.sv
// Self-checking bench for the calibration walker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %0t got %h expected %h", $time, g, e); \
  end end
module tcw_walker_bench;
  logic        clk = 1'b0;
  logic        arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, info_rd;
  logic        range_select_we, osc_step_mod_we;
  logic [7:0]  wb_adr_i, range_select_reg, osc_step_mod_reg, r;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] info_addr, info_rdata;
  logic [15:0] cal [8];
  logic [8:0]  wq [$];
  int          miscompares = 0, n_compared = 0, cycles = 0, f;
  always #5 clk = ~clk;
  tcw_walker uut (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .info_rd, .info_addr,
    .info_rdata, .range_select_we, .range_select_reg, .osc_step_mod_we,
    .osc_step_mod_reg);
  tcw_flash_model fl (.clk, .info_rd, .info_addr, .info_rdata);
  // Log clock-control writes in order, range entries flagged by bit 8
  always @(posedge clk) begin
    if (osc_step_mod_we === 1'b1) wq.push_back({1'b0, osc_step_mod_reg});
    if (range_select_we === 1'b1) wq.push_back({1'b1, range_select_reg});
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // Ack and read data sampled at the same rising edge
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb
  // Poll status until idle and not busy; last status stays in q
  task automatic wait_idle();
    do begin
      wb(1'b0, tcw_pkg::REG_STATUS, 32'h0, 4'h1);
    end while (q[1:0] !== 2'b10);
    @(negedge clk);
  endtask : wait_idle
  task automatic corr(input logic [31:0] c, input logic [15:0] w, e);
    wb(1'b1, tcw_pkg::REG_CTRL, c, 4'h1);
    wb(1'b1, tcw_pkg::REG_RAW, {16'h0000, w}, 4'h1);
    repeat (3) @(posedge clk);
    wb(1'b0, tcw_pkg::REG_RESULT, 32'h0, 4'h1);
    `CHK(q[15:0], e)
  endtask : corr
  // Segment image: filler, converter record, unknown tag, oscillator record
  task automatic load();
    logic [15:0] x;
    x = 16'h0000;
    for (int i = 0; i < 32; i++) fl.mem[i] = 16'hFFFF;
    fl.mem[1]  = 16'h16FE;
    fl.mem[13] = 16'h1008;
    for (int i = 0; i < 8; i++) fl.mem[14 + i] = cal[i];
    fl.mem[22] = 16'h0855;
    fl.mem[27] = 16'h0801;
    for (int i = 0; i < 4; i++) fl.mem[28 + i] = 16'hA1A0 + 16'(i * 16'h0202);
    for (int i = 1; i < 32; i++) x = x ^ fl.mem[i];
    fl.mem[0] = -x;
  endtask : load
  initial begin
    arst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    cal = '{16'h8010, 16'hFFFE, 16'h7BBB, 16'h0A11, 16'h0B22, 16'h8123,
            16'h0C33, 16'h0D44};
    load();
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, tcw_pkg::REG_STATUS, 32'h0, 4'h1);
    `CHK(q, 32'h0000_0002)
    wb(1'b1, tcw_pkg::REG_MASK, 32'h0000_0007, 4'h0);
    wb(1'b0, tcw_pkg::REG_MASK, 32'h0, 4'h1);
    `CHK(q, 32'h0000_0000)
    wb(1'b0, 8'hFC, 32'h0, 4'h1);
    `CHK(q, 32'h0000_0000)
    wb(1'b1, tcw_pkg::REG_MASK, 32'h0000_0007, 4'h1);
    for (f = 0; f < 4; f++) begin
      wq.delete();
      wb(1'b1, tcw_pkg::REG_CTRL, 32'(f * 2 + 1), 4'h1);
      wait_idle();
      `CHK(irq, 1'b1)
      wb(1'b0, tcw_pkg::REG_IRQ, 32'h0, 4'h1);
      `CHK(q, 32'h0000_0001)
      @(negedge clk);
      `CHK(irq, 1'b0)
      r = 8'hA7 - 8'(2 * f);
      `CHK(wq.size(), 3)
      `CHK(wq[0], 9'h000)
      `CHK(wq[1], {1'b1, r})
      `CHK(wq[2], {1'b0, r - 8'h01})
      wb(1'b0, tcw_pkg::REG_OSC, 32'h0, 4'h1);
      `CHK(q, {16'h0000, r, r - 8'h01})
    end
    wb(1'b0, tcw_pkg::REG_STATUS, 32'h0, 4'h1);
    `CHK(q, 32'h0000_001A)
    for (f = 0; f < 8; f++) begin
      wb(1'b0, tcw_pkg::REG_CAL_BASE + 8'(4 * f), 32'h0, 4'h1);
      `CHK(q, {16'h0000, cal[f]})
    end
    corr(32'h0, 16'h0100, 16'((32'h100 * cal[2]) >> 15));
    corr(32'h8, 16'h0123, 16'((32'h123 * cal[5]) >> 15));
    corr(32'h30, 16'h0800, 16'((32'h800 * cal[0]) >> 15) + cal[1]);
    wb(1'b0, tcw_pkg::REG_IRQ, 32'h0, 4'h1);
    `CHK(q, 32'h0000_0004)
    wb(1'b1, tcw_pkg::REG_MASK, 32'h0, 4'h1);
    fl.mem[5] = fl.mem[5] ^ 16'h0001;
    wq.delete();
    wb(1'b1, tcw_pkg::REG_CTRL, 32'h1, 4'h1);
    wait_idle();
    `CHK(q[2], 1'b1)
    `CHK(wq.size(), 0)
    `CHK(irq, 1'b0)
    wb(1'b1, tcw_pkg::REG_MASK, 32'h0000_0002, 4'h1);
    @(negedge clk);
    `CHK(irq, 1'b1)
    wb(1'b0, tcw_pkg::REG_IRQ, 32'h0, 4'h1);
    `CHK(q[1], 1'b1)
    stop_test();
  end
endmodule : tcw_walker_bench
`default_nettype wire
